/* File: asc_pkg.sv */
// Purpose: Shared constants and types for the serial control-word block
// Assumes: 40 MHz core clock, host-driven serial clock sampled by it
// Notes:   Codes, bit counts, widths, timing and the control-word and power-down reset values live here

`default_nettype none

package asc_pkg;
	// ----------------------------------------------------------------
	// Selector codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_ANALOG_INPUT_ZERO = 4'h0;
	localparam logic [3:0] SEL_ANALOG_INPUT_TEN  = 4'ha;
	localparam logic [3:0] SEL_TEST_HALF         = 4'hb;
	localparam logic [3:0] SEL_TEST_LOW          = 4'hc;
	localparam logic [3:0] SEL_TEST_HIGH         = 4'hd;
	localparam logic [3:0] SEL_PWR_DOWN          = 4'he;

	// ----------------------------------------------------------------
	// Length codes and bit counts
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_8      = 2'h1;
	localparam logic [1:0] LEN_16     = 2'h3;
	localparam logic [4:0] BITS_8     = 5'h08;
	localparam logic [4:0] BITS_12    = 5'h0c;
	localparam logic [4:0] BITS_16    = 5'h10;
	localparam logic [4:0] SAMPLE_FALL = 5'h03;
	localparam logic [3:0] LEN_RISE   = 4'h5;
	localparam logic [3:0] CTRL_BITS  = 4'h8;

	// ----------------------------------------------------------------
	// Widths, reset values, timing
	// ----------------------------------------------------------------
	localparam int         RES_W      = 12;
	localparam int         WORD_W     = 16;
	localparam int         FIFO_DEPTH = 8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic       PD_RESET   = 1'b1;
	localparam int CLK_PERIOD_NS = 25;
	localparam int EOC_DELAY_NS  = 100;
	localparam int EOC_DELAY_CYC = (EOC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] EOC_DELAY_LOAD = 3'(EOC_DELAY_CYC - 1);

	typedef struct packed {
		logic [3:0] sel;
		logic       length_sel_hi;
		logic       length_sel_lo;
		logic       bit_order_flag;
		logic       polarity_flag;
	} asc_ctrl_type;

	typedef enum logic [2:0] {
		ST_IO    = 3'b001,
		ST_DELAY = 3'b010,
		ST_CONV  = 3'b100
	} asc_state_type;
endpackage

`default_nettype wire

/* File: asc_fifo.sv */
// Purpose: Small result FIFO between converter and output register
// Assumes: Single clock, synchronous push and pop
// Notes:   Read data come straight from the storage registers

`timescale 1ns/100ps
`default_nettype none

module asc_fifo #(
	parameter int W = 12,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = $clog2(D);

	logic [W-1:0] mem_r [D];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0]   count_r;
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	assign in_ready  = (count_r != (PW+1)'(D));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

`default_nettype wire

/* File: asc_ctrl.sv */
// Purpose: Control-word decode and I/O-cycle framing of a serial converter
// Assumes: Serial clock, chip select and data in are asynchronous pins
// Notes:   Converter core is outside; results arrive through a FIFO

`timescale 1ns/100ps
`default_nettype none

module asc_ctrl (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        cs_n,
	input  wire logic        io_clk,
	input  wire logic        data_in,
	output logic             data_out,
	output logic             data_out_oe,
	output logic             eoc,
	output logic             sampling,
	output logic             power_down,
	output logic             conv_start,
	output logic [3:0]       conv_sel,
	input  wire logic        res_valid,
	output logic             res_ready,
	input  wire logic [11:0] res_data
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic clk_m_r, clk_s_r, clk_d_r;
	logic cs_m_r, cs_s_r;
	logic din_m_r, din_s_r;

	// First stages feed only the second stages
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_m_r <= 1'b0;
			clk_s_r <= 1'b0;
			clk_d_r <= 1'b0;
			cs_m_r  <= 1'b1;
			cs_s_r  <= 1'b1;
			din_m_r <= 1'b0;
			din_s_r <= 1'b0;
		end else begin
			clk_m_r <= io_clk;
			clk_s_r <= clk_m_r;
			clk_d_r <= clk_s_r;
			cs_m_r  <= cs_n;
			cs_s_r  <= cs_m_r;
			din_m_r <= data_in;
			din_s_r <= din_m_r;
		end
	end

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	asc_pkg::asc_state_type state_r, state_nxt;
	logic [7:0]  shift_r;
	logic [3:0]  rise_cnt_r;
	logic [4:0]  fall_cnt_r;
	logic [1:0]  len_prev_r;
	logic [1:0]  len_now_r;
	logic        len_new_r;
	logic        order_r;
	logic        pol_conv_r;
	logic        len8_conv_r;
	logic [2:0]  dly_cnt_r;
	logic [15:0] word_r;
	logic        eoc_r;
	logic        samp_r;
	logic        pd_r;
	logic        start_r;
	logic        dout_r;
	logic        oe_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Clock and data are ignored with chip select high or outside I/O
	wire        active   = !cs_s_r && (state_r == asc_pkg::ST_IO);
	wire        rise     = active && clk_s_r && !clk_d_r;
	wire        fall     = active && !clk_s_r && clk_d_r;
	// Previous length frames the cycle until the new field is complete
	wire [1:0]  len_eff  = len_new_r ? len_now_r : len_prev_r;
	wire [4:0]  len_bits = (len_eff == asc_pkg::LEN_8)  ? asc_pkg::BITS_8 :
	                       (len_eff == asc_pkg::LEN_16) ? asc_pkg::BITS_16 :
	                       asc_pkg::BITS_12;
	wire [4:0]  fall_inc = fall_cnt_r + 5'h01;
	wire        io_end   = fall && (fall_inc == len_bits);
	wire        samp_pt  = fall && (fall_cnt_r == asc_pkg::SAMPLE_FALL);
	wire [3:0]  sel_now  = shift_r[3:0];
	wire        sel_pd   = (sel_now == asc_pkg::SEL_PWR_DOWN);
	// Complete word seen through its fields once all eight bits are in
	asc_pkg::asc_ctrl_type word_in;
	assign word_in = asc_pkg::asc_ctrl_type'(shift_r);
	wire        end_pd   = (word_in.sel == asc_pkg::SEL_PWR_DOWN);
	wire        take_bit = rise && (rise_cnt_r < asc_pkg::CTRL_BITS);
	wire        take_len = rise && (rise_cnt_r == asc_pkg::LEN_RISE);
	// Output bit index; LSB first starts at the low end of the frame
	wire [4:0]  idx_msb  = 5'h0f - fall_cnt_r;
	wire [4:0]  idx_lsb  = asc_pkg::BITS_16 - len_bits + fall_cnt_r;
	wire [3:0]  idx      = order_r ? idx_lsb[3:0] : idx_msb[3:0];
	wire        fifo_valid;
	wire [11:0] fifo_data;
	wire        pop      = (state_r == asc_pkg::ST_CONV) && fifo_valid;
	// MSB inversion is all that separates the two codings
	wire [11:0] coded    = {fifo_data[11] ^ pol_conv_r, fifo_data[10:0]};

	// ----------------------------------------------------------------
	// Result FIFO; it drains only while a conversion is awaited
	// ----------------------------------------------------------------
	asc_fifo #(
		.W (asc_pkg::RES_W),
		.D (asc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (core_clk),
		.rst       (sys_rst),
		.in_valid  (res_valid),
		.in_ready  (res_ready),
		.in_data   (res_data),
		.out_valid (fifo_valid),
		.out_ready (state_r == asc_pkg::ST_CONV),
		.out_data  (fifo_data)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Power-down selection skips the conversion entirely
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			asc_pkg::ST_IO: begin
				if (io_end && !end_pd) begin
					state_nxt = asc_pkg::ST_DELAY;
				end
			end
			asc_pkg::ST_DELAY: begin
				if (dly_cnt_r == 3'h1) begin
					state_nxt = asc_pkg::ST_CONV;
				end
			end
			asc_pkg::ST_CONV: begin
				if (pop) begin
					state_nxt = asc_pkg::ST_IO;
				end
			end
			default: state_nxt = asc_pkg::ST_IO;
		endcase
	end

	// Serial input capture; counters clear while deselected
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_r    <= asc_pkg::CTRL_RESET;
			rise_cnt_r <= '0;
			fall_cnt_r <= '0;
			len_now_r  <= '0;
			len_new_r  <= 1'b0;
		end else if (cs_s_r || io_end) begin
			rise_cnt_r <= '0;
			fall_cnt_r <= '0;
			len_new_r  <= 1'b0;
		end else begin
			if (take_bit) begin
				shift_r    <= {shift_r[6:0], din_s_r};
				rise_cnt_r <= rise_cnt_r + 4'h1;
			end
			if (take_len) begin
				len_now_r <= {shift_r[0], din_s_r};
				len_new_r <= 1'b1;
			end
			if (fall) begin
				fall_cnt_r <= fall_inc;
			end
		end
	end

	// Control word takes effect at the end of its I/O cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			len_prev_r  <= '0;
			order_r     <= 1'b0;
			pol_conv_r  <= 1'b0;
			len8_conv_r <= 1'b0;
		end else if (io_end) begin
			len_prev_r  <= len_eff;
			order_r     <= word_in.bit_order_flag;
			pol_conv_r  <= word_in.polarity_flag;
			len8_conv_r <= (len_eff == asc_pkg::LEN_8);
		end
	end

	// Sampling window and power-down flag
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			samp_r <= 1'b0;
			pd_r   <= asc_pkg::PD_RESET;
		end else if (io_end) begin
			samp_r <= 1'b0;
		end else if (samp_pt) begin
			samp_r <= !sel_pd;
			pd_r   <= sel_pd;
		end
	end

	// Conversion handshake: delay, start pulse, latch of the result
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r   <= asc_pkg::ST_IO;
			dly_cnt_r <= '0;
			eoc_r     <= 1'b1;
			start_r   <= 1'b0;
			word_r    <= '0;
		end else begin
			state_r <= state_nxt;
			start_r <= (state_r == asc_pkg::ST_DELAY) && (dly_cnt_r == 3'h1);
			if (io_end) begin
				dly_cnt_r <= asc_pkg::EOC_DELAY_LOAD;
			end else if (dly_cnt_r != 3'h0) begin
				dly_cnt_r <= dly_cnt_r - 3'h1;
			end
			if ((state_r == asc_pkg::ST_DELAY) && (dly_cnt_r == 3'h1)) begin
				eoc_r <= 1'b0;
			end else if (pop) begin
				eoc_r <= 1'b1;
			end
			if (pop) begin
				word_r <= len8_conv_r ? {coded[11:4], 8'h00} : {coded, 4'h0};
			end
		end
	end

	// Selector is latched at the end of the cycle for the next conversion
	logic [3:0] sel_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_r <= asc_pkg::SEL_ANALOG_INPUT_ZERO;
		end else if (io_end) begin
			sel_r <= word_in.sel;
		end
	end

	// Serial output; forced low outside the I/O state, from the end of a converting cycle until the new result
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_r <= 1'b0;
			oe_r   <= 1'b0;
		end else begin
			oe_r   <= !cs_s_r;
			dout_r <= (state_r == asc_pkg::ST_IO) && word_r[idx];
		end
	end

	assign data_out    = dout_r;
	assign data_out_oe = oe_r;
	assign eoc         = eoc_r;
	assign sampling    = samp_r;
	assign power_down  = pd_r;
	assign conv_start  = start_r;
	assign conv_sel    = sel_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_eoc_drop;
		eoc_r[*3] ##1 (!eoc_r && start_r);
	endsequence

	sequence s_no_start;
		(!start_r)[*6];
	endsequence

	a_eoc_fall_delay: assert property (io_end && !end_pd |=> s_eoc_drop)
		else $error("conversion-done did not drop after the fixed delay");
	a_sel_to_conv: assert property (io_end && !end_pd |-> ##4 (conv_sel == $past(shift_r[7:4], 4)))
		else $error("conversion selector not taken from the finished word");
	a_pd_skips: assert property (io_end && end_pd |=> s_no_start)
		else $error("power-down word started a conversion");
	a_pad_bits: assert property (!len8_conv_r && $past(pop) |-> word_r[3:0] == 4'h0)
		else $error("pad bits not zero");
	a_trunc8: assert property (len8_conv_r && $past(pop) |-> word_r[7:0] == 8'h00)
		else $error("low bits kept in 8-bit mode");
	a_msb_code: assert property (pop |=> word_r[15] == ($past(fifo_data[11]) ^ $past(pol_conv_r)))
		else $error("result MSB coding wrong");
	a_samp_window: assert property (samp_pt && !sel_pd |=> samp_r until_with io_end)
		else $error("sampling not held through the cycle");
	a_samp_stop: assert property (io_end |=> !samp_r)
		else $error("sampling still on after the cycle");
	a_eoc_rise: assert property (pop |=> eoc_r && (state_r == asc_pkg::ST_IO))
		else $error("conversion-done not raised at latch");
	a_out_low: assert property (!eoc_r |=> !data_out)
		else $error("serial output not forced low during conversion");
	a_cs_release: assert property (cs_s_r |=> !data_out_oe)
		else $error("output driven while deselected");
	a_order_hold: assert property (!io_end |=> $stable(order_r))
		else $error("bit order changed within a cycle");
	// Expected count comes from the received field, not from the framing path
	a_len_frame: assert property (io_end |-> fall_inc == (
		({word_in.length_sel_hi, word_in.length_sel_lo} == asc_pkg::LEN_8)  ? asc_pkg::BITS_8 :
		({word_in.length_sel_hi, word_in.length_sel_lo} == asc_pkg::LEN_16) ? asc_pkg::BITS_16 :
		asc_pkg::BITS_12))
		else $error("cycle closed at the wrong edge count");
endmodule

`default_nettype wire

/* File: asc_host_model.sv */
// Purpose: Host serial port model that drives the control-word link
// Assumes: 40 MHz core clock; the 200 ns serial clock is made here
// Notes:   Pins change on core_clk falling edges only

`timescale 1ns/100ps
`default_nettype none

module asc_host_model (
	input  wire logic core_clk,
	output logic      cs_n,
	output logic      io_clk,
	output logic      data_in,
	input  wire logic data_out,
	input  wire logic sampling
);
	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	// Deselected and clock low, so nothing is framed before the first task
	initial begin
		cs_n    = 1'b1;
		io_clk  = 1'b0;
		data_in = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame tasks
	// ------------------------------------------------------------
	// One I/O cycle of n clocks; the serial clock is low at the start and left low at the end
	task automatic xfer(input logic [7:0] ctrl, input int n, output logic [15:0] rx,
		output logic [15:0] sp);
		int k;
		rx = 16'h0000;
		sp = 16'h0000;
		@(negedge core_clk);
		cs_n = 1'b0;
		repeat (8) @(negedge core_clk);
		for (k = 0; k < n; k++) begin
			// Data in is held after the word to keep the sample quiet
			if (k < 8) begin
				data_in = ctrl[7 - k];
			end
			repeat (4) @(negedge core_clk);
			io_clk = 1'b1;
			repeat (4) @(negedge core_clk);
			rx     = {rx[14:0], data_out};
			sp     = {sp[14:0], sampling};
			io_clk = 1'b0;
		end
	endtask

	// Clocks while deselected, with data toggling so any capture would show
	task automatic idle(input int m);
		int k;
		@(negedge core_clk);
		cs_n = 1'b1;
		for (k = 0; k < m; k++) begin
			repeat (4) @(negedge core_clk);
			io_clk  = 1'b1;
			data_in = ~data_in;
			repeat (4) @(negedge core_clk);
			io_clk = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the serial control-word block
// Assumes: Host model drives the link; the bench plays the converter core
// Notes:   Expected serial words are modelled from the control words sent

`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("FAIL t=%0t got %h exp %h", $time, (a), (b)); \
	end \
end

module tb_top;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        core_clk        = 1'b0;
	logic        sys_rst         = 1'b1;
	logic        cs_n;
	logic        io_clk;
	logic        data_in;
	logic        data_out;
	logic        data_out_oe;
	logic        eoc;
	logic        sampling;
	logic        power_down;
	logic        conv_start;
	logic [3:0]  conv_sel;
	logic        res_valid       = 1'b0;
	logic        res_ready;
	logic [11:0] res_data        = 12'h000;
	logic        took            = 1'b0;
	logic [11:0] res_q[$];
	logic [11:0] exp_q[$];
	logic [11:0] code_gen        = 12'ha5c;
	logic [15:0] word_m          = 16'h0000;
	logic        ord_m           = 1'b0;
	int          n_conv          = 0;
	int          cyc             = 0;
	int          n_mismatch      = 0;
	int          samples_checked = 0;

	asc_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n), .io_clk(io_clk),
		.data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
		.sampling(sampling), .power_down(power_down), .conv_start(conv_start),
		.conv_sel(conv_sel), .res_valid(res_valid), .res_ready(res_ready),
		.res_data(res_data));

	asc_host_model i_host (.core_clk(core_clk), .cs_n(cs_n), .io_clk(io_clk),
		.data_in(data_in), .data_out(data_out), .sampling(sampling));

	// ------------------------------------------------------------
	// Clock, converter stand-in, watchdog
	// ------------------------------------------------------------
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// Results are offered until taken; idle data toggles so stale values never match
	always @(posedge core_clk) took <= res_valid && res_ready;
	always @(negedge core_clk) begin
		if (took === 1'b1) res_q.delete(0);
		res_valid = (res_q.size() > 0);
		if (res_q.size() > 0) res_data = res_q[0];
		else res_data = ~res_data;
	end

	// Counts conversions and cuts a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (conv_start === 1'b1) n_conv++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Model and shared tasks
	// ------------------------------------------------------------
	function automatic int lenb(input logic [1:0] f);
		if (f === asc_pkg::LEN_8) return 8;
		if (f === asc_pkg::LEN_16) return 16;
		return 12;
	endfunction

	// MSB-justified output word; 8-bit drops the low nibble, 16-bit pads zeros
	function automatic logic [15:0] fmt(input logic [11:0] c, input logic pol, input int n);
		logic [15:0] w;
		w = {c[11] ^ pol, c[10:0], 4'h0};
		if (n == 8) w[7:0] = 8'h00;
		return w;
	endfunction

	// Bits in the order they appear on the pin, first bit at the top
	function automatic logic [15:0] ser(input logic [15:0] w, input logic ord, input int n);
		int k;
		logic [15:0] r;
		r = 16'h0000;
		for (k = 0; k < n; k++) r = {r[14:0], ord ? w[16 - n + k] : w[15 - k]};
		return r;
	endfunction

	task automatic push;
		res_q.push_back(code_gen);
		exp_q.push_back(code_gen);
		code_gen = code_gen + 12'h2d7;
	endtask

	// One I/O cycle, then the conversion it starts, judged against the model
	task automatic xact(input logic [7:0] ctrl);
		logic [15:0] rx, sp, e;
		int n, c0, i;
		logic pd;
		n  = lenb(ctrl[3:2]);
		pd = (ctrl[7:4] === asc_pkg::SEL_PWR_DOWN);
		if (!pd && exp_q.size() == 0) push();
		e  = ser(word_m, ord_m, n);
		c0 = n_conv;
		i_host.xfer(ctrl, n, rx, sp);
		`CHK(rx, e);
		`CHK(sp, pd ? 16'h0000 : 16'((1 << (n - 4)) - 1));
		repeat (16) @(negedge core_clk);
		for (i = 0; i < 400; i++) begin
			if (eoc === 1'b1) break;
			@(negedge core_clk);
		end
		`CHK(n_conv - c0, pd ? 0 : 1);
		`CHK(power_down, pd);
		`CHK(data_out_oe, 1'b1);
		if (!pd) begin
			`CHK(conv_sel, ctrl[7:4]);
			word_m = fmt(exp_q.pop_front(), ctrl[0], n);
		end
		ord_m = ctrl[1];
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset levels, then results queued until the buffer refuses
	task automatic t_reset;
		int i;
		`CHK(data_out_oe, 1'b0);
		`CHK(eoc, 1'b1);
		`CHK(power_down, 1'b1);
		for (i = 0; i < 9; i++) push();
		repeat (20) @(negedge core_clk);
		`CHK(res_ready, 1'b0);
		`CHK(res_q.size(), 1);
		$display("test reset done");
	endtask

	// Every length code, with length changes in MSB-first order
	task automatic t_lengths;
		xact(8'h30);
		xact(8'h34);
		xact(8'h34);
		xact(8'h38);
		xact(8'h3c);
		xact(8'h3c);
		$display("test lengths done");
	endtask

	// All inputs and test codes, then power down keeping the old result
	task automatic t_selectors;
		int s;
		for (s = 0; s <= int'(asc_pkg::SEL_TEST_HIGH); s++) begin
			xact({4'(s), 4'h0});
		end
		xact({asc_pkg::SEL_PWR_DOWN, 4'h0});
		xact(8'h10);
		$display("test selectors done");
	endtask

	// Bit order flips take effect one cycle late, lengths kept stable in LSB first
	task automatic t_order;
		xact(8'h3e);
		xact(8'h3e);
		xact(8'h3c);
		xact(8'h3a);
		xact(8'h3a);
		xact(8'h30);
		$display("test order done");
	endtask

	// Polarity applies to the conversion it starts, not the current output
	task automatic t_polarity;
		xact(8'h31);
		xact(8'h31);
		xact(8'h35);
		xact(8'h30);
		xact(8'h30);
		$display("test polarity done");
	endtask

	// Clocks while deselected change nothing; buffer ends drained
	task automatic t_deselect;
		int c0;
		c0 = n_conv;
		i_host.idle(3);
		`CHK(data_out_oe, 1'b0);
		`CHK(eoc, 1'b1);
		`CHK(n_conv, c0);
		xact(8'h30);
		`CHK(res_ready, 1'b1);
		$display("test deselect done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge core_clk);
		t_reset();
		t_lengths();
		t_selectors();
		t_order();
		t_polarity();
		t_deselect();
		summarize();
	end
endmodule

`default_nettype wire
